// file: rtl/bus_cycle_termination.sv
// Bus cycle termination decision logic
`timescale 1ns/1ps
`default_nettype none
// Contract
// RULE_01 - Partner changes inputs on rising edges
// RULE_02 - Ack alone: normal end, continue
// RULE_03 - Halt with/before ack: end, then halt
// RULE_04 - Error without halt: bus error trap
// RULE_05 - Partner drops error not before ack
// RULE_06 - Error plus halt: wait, then re-run
// RULE_07 - Partner holds halt after error drops
// RULE_08 - Error then halt two states later: re-run
// RULE_09 - Evaluate even states, compare two apart
// RULE_10 - Bus error end: trap next cycle
// RULE_11 - Wrong release order: trap vector zero
// RULE_12 - Error released before halt: re-run
// RULE_13 - Lingering error/halt may stretch next cycle
// RULE_14 - Error never released: next cycle errors
// RULE_15 - Partner releases ack/error with strobe
// RULE_16 - Strobe starts cycle, handshake controls transfer
// RULE_17 - Watchdog asserts ack and error together
// RULE_18 - Checker uses error+halt or error+ack
// RULE_19 - Bus error trap uses vector two
// RULE_20 - Never re-run read-modify-write cycle
// RULE_21 - Error sampled from state 2, ack 4
module bus_cycle_termination (
    // Clock and reset
    input  wire logic       CLK,
    input  wire logic       SYS_RST,
    // Cycle control from the bus sequencer
    input  wire logic       CYCLE_START,
    input  wire logic       RMW_CYCLE,
    // Termination pins
    input  wire logic       TRANSFER_ACK_N,
    input  wire logic       BUS_ERROR_N,
    input  wire logic       HALT_N,
    // Results
    output var  logic       ADDR_STROBE_N,
    output var  logic       CYCLE_DONE,
    output var  logic [1:0] OUTCOME,
    output var  logic       TRAP_REQ,
    output var  logic [7:0] TRAP_VECTOR,
    output var  logic       HALTED,
    output var  logic       RERUN_REQ,
    output var  logic       STRETCH
);
    import bus_term_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_ACTIVE = 3'b001,
        ST_HALTED = 3'b010,
        ST_ERRWT  = 3'b011,
        ST_RERUN  = 3'b100
    } state_t;

    term_in_t pins, sync;
    state_t   state, next_state;
    logic [3:0] bstate, next_bstate;
    term_in_t prev_even, next_prev_even;
    logic       rmw, next_rmw;
    logic       bus_error_n_seen, next_bus_error_n_seen;
    logic       next_as_n, next_done, next_trap, next_halted, next_rerun, next_stretch;
    logic [1:0] next_outcome;
    logic [7:0] next_vec;
    logic       err_stuck, next_err_stuck;

    function automatic logic asserted(input logic pin_n);
        return ~pin_n;
    endfunction

    assign pins = '{transfer_ack_n: TRANSFER_ACK_N, bus_error_n: BUS_ERROR_N, halt_n: HALT_N};

    // External pins pass the three-stage synchroniser
    term_sync u_sync (
        .clk  (CLK),
        .rst  (SYS_RST),
        .din  (pins),
        .dout (sync)
    );

    always_comb begin
        next_state     = state;
        next_bstate    = bstate;
        next_prev_even = prev_even;
        next_rmw       = rmw;
        next_bus_error_n_seen = bus_error_n_seen;
        next_err_stuck = err_stuck;
        next_as_n      = ADDR_STROBE_N;
        next_done      = 1'b0;
        next_trap      = 1'b0;
        next_outcome   = OUTCOME;
        next_vec       = TRAP_VECTOR;
        next_halted    = HALTED;
        next_rerun     = 1'b0;
        next_stretch   = 1'b0;
        case (state)
            ST_IDLE: begin
                if (CYCLE_START) begin
                    next_state     = ST_ACTIVE; // RULE_16
                    next_as_n      = 1'b0;
                    next_bstate    = 4'h0;
                    next_rmw       = RMW_CYCLE;
                    next_bus_error_n_seen = 1'b0;
                    next_prev_even = 3'b111;
                    // RULE_13
                    next_stretch   = asserted(sync.bus_error_n) | asserted(sync.halt_n);
                end
            end
            ST_ACTIVE: begin
                next_bstate = (bstate == STATE_COUNT_MAX) ? ACK_FIRST_STATE : bstate + 4'h1;
                if (bstate >= BUS_ERROR_N_FIRST_STATE && asserted(sync.bus_error_n)) begin
                    next_bus_error_n_seen = 1'b1; // RULE_21
                end
                // RULE_09
                if (bstate[0] == 1'b0 && bstate >= ACK_FIRST_STATE) begin
                    next_prev_even = sync;
                    if (err_stuck || asserted(sync.bus_error_n) || bus_error_n_seen) begin
                        // RULE_14 RULE_04 RULE_06 RULE_08 RULE_20
                        if (asserted(sync.halt_n) && !rmw && !err_stuck) begin
                            next_outcome = OUT_RERUN;
                            next_state   = ST_RERUN;
                        end else if (!asserted(prev_even.bus_error_n) && !err_stuck
                                     && asserted(sync.bus_error_n)) begin
                            next_outcome = outcome_t'(OUTCOME); // Wait one more even state
                        end else begin
                            next_outcome = OUT_TRAP;
                            next_state   = ST_ERRWT;
                        end
                        if (next_state != ST_ACTIVE) begin
                            next_done = 1'b1;
                            next_as_n = 1'b1;
                        end
                    end else if (asserted(sync.transfer_ack_n)) begin
                        next_done = 1'b1;
                        next_as_n = 1'b1;
                        if (asserted(sync.halt_n)) begin
                            next_outcome = OUT_HALT; // RULE_03
                            next_state   = ST_HALTED;
                            next_halted  = 1'b1;
                        end else begin
                            next_outcome = OUT_NORMAL; // RULE_02
                            next_state   = ST_IDLE;
                        end
                    end
                end
            end
            ST_HALTED: begin
                if (!asserted(sync.halt_n)) begin
                    next_halted    = 1'b0;
                    next_state     = ST_IDLE;
                    next_err_stuck = asserted(sync.bus_error_n);
                end
            end
            ST_ERRWT: begin
                // RULE_10 RULE_19
                if (!asserted(sync.bus_error_n) && !asserted(sync.halt_n)) begin
                    next_trap      = 1'b1;
                    next_vec       = TRAP_VEC_BUS_ERROR;
                    next_state     = ST_IDLE;
                    next_err_stuck = 1'b0;
                end
            end
            ST_RERUN: begin
                next_halted = 1'b1;
                if (!asserted(sync.halt_n)) begin
                    next_halted = 1'b0;
                    next_state  = ST_IDLE;
                    if (asserted(sync.bus_error_n) || asserted(prev_even.bus_error_n)) begin
                        next_trap = 1'b1; // RULE_11
                        next_vec  = TRAP_VEC_ILLEGAL;
                    end else begin
                        next_rerun = 1'b1; // RULE_12
                    end
                end else begin
                    next_prev_even = sync;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            state         <= ST_IDLE;
            bstate        <= 4'h0;
            prev_even     <= 3'b111;
            rmw           <= 1'b0;
            bus_error_n_seen     <= 1'b0;
            err_stuck     <= 1'b0;
            ADDR_STROBE_N <= 1'b1;
            CYCLE_DONE    <= 1'b0;
            OUTCOME       <= OUT_NORMAL;
            TRAP_REQ      <= 1'b0;
            TRAP_VECTOR   <= 8'h00;
            HALTED        <= 1'b0;
            RERUN_REQ     <= 1'b0;
            STRETCH       <= 1'b0;
        end else begin
            state         <= next_state;
            bstate        <= next_bstate;
            prev_even     <= next_prev_even;
            rmw           <= next_rmw;
            bus_error_n_seen     <= next_bus_error_n_seen;
            err_stuck     <= next_err_stuck;
            ADDR_STROBE_N <= next_as_n;
            CYCLE_DONE    <= next_done;
            OUTCOME       <= next_outcome;
            TRAP_REQ      <= next_trap;
            TRAP_VECTOR   <= next_vec;
            HALTED        <= next_halted;
            RERUN_REQ     <= next_rerun;
            STRETCH       <= next_stretch;
        end
    end

    property p_normal_end;
        @(posedge CLK) disable iff (SYS_RST)
        (state == ST_ACTIVE && bstate[0] == 1'b0 && bstate >= ACK_FIRST_STATE && !err_stuck && !bus_error_n_seen
         && sync == 3'b011) |=> (CYCLE_DONE && OUTCOME == OUT_NORMAL && state == ST_IDLE);
    endproperty
    a_normal_end: assert property (p_normal_end) else $error("normal end wrong"); // RULE_02

    property p_halt_end;
        @(posedge CLK) disable iff (SYS_RST)
        (state == ST_ACTIVE && bstate[0] == 1'b0 && bstate >= ACK_FIRST_STATE && !err_stuck && !bus_error_n_seen
         && sync == 3'b010) |=> (HALTED && OUTCOME == OUT_HALT);
    endproperty
    a_halt_end: assert property (p_halt_end) else $error("halt end wrong"); // RULE_03

    property p_trap_vec;
        @(posedge CLK) disable iff (SYS_RST)
        (state == ST_ERRWT && sync.bus_error_n && sync.halt_n) |=> (TRAP_REQ && TRAP_VECTOR == TRAP_VEC_BUS_ERROR);
    endproperty
    a_trap_vec: assert property (p_trap_vec) else $error("bus error trap missing"); // RULE_10

    property p_no_rmw_rerun;
        @(posedge CLK) disable iff (SYS_RST)
        rmw |-> state != ST_RERUN;
    endproperty
    a_no_rmw_rerun: assert property (p_no_rmw_rerun) else $error("rmw cycle re-run"); // RULE_20

    property p_rerun_ok;
        @(posedge CLK) disable iff (SYS_RST)
        (state == ST_RERUN && sync == 3'b111 && prev_even.bus_error_n) |=> (RERUN_REQ && !TRAP_REQ);
    endproperty
    a_rerun_ok: assert property (p_rerun_ok) else $error("re-run not requested"); // RULE_12

    property p_illegal;
        @(posedge CLK) disable iff (SYS_RST)
        (state == ST_RERUN && sync.halt_n && !sync.bus_error_n) |=> (TRAP_REQ && TRAP_VECTOR == TRAP_VEC_ILLEGAL);
    endproperty
    a_illegal: assert property (p_illegal) else $error("illegal order not trapped"); // RULE_11

    property p_odd_quiet;
        @(posedge CLK) disable iff (SYS_RST)
        (state == ST_ACTIVE && bstate[0]) |=> !CYCLE_DONE;
    endproperty
    a_odd_quiet: assert property (p_odd_quiet) else $error("decision in odd state"); // RULE_09

    property p_halted_holds;
        @(posedge CLK) disable iff (SYS_RST)
        (state == ST_HALTED && !sync.halt_n) |=> (HALTED && state == ST_HALTED);
    endproperty
    a_halted_holds: assert property (p_halted_holds) else $error("halt released early"); // RULE_03

    property p_rerun_wait;
        @(posedge CLK) disable iff (SYS_RST)
        (state == ST_RERUN && !sync.halt_n) |=> (HALTED && state == ST_RERUN);
    endproperty
    a_rerun_wait: assert property (p_rerun_wait) else $error("re-run wait left early"); // RULE_06

    property p_stuck_trap;
        @(posedge CLK) disable iff (SYS_RST)
        (state == ST_ACTIVE && err_stuck && bstate[0] == 1'b0 && bstate >= ACK_FIRST_STATE)
        |=> (CYCLE_DONE && OUTCOME == OUT_TRAP);
    endproperty
    a_stuck_trap: assert property (p_stuck_trap) else $error("stuck error not trapped"); // RULE_14
endmodule
`default_nettype wire

// file: rtl/bus_term_pkg.sv
// Shared types and constants for the bus cycle termination block
package bus_term_pkg;
    localparam logic [7:0] TRAP_VEC_BUS_ERROR   = 8'h02;
    localparam logic [7:0] TRAP_VEC_ILLEGAL     = 8'h00;
    localparam logic [3:0] BUS_ERROR_N_FIRST_STATE     = 4'h2;
    localparam logic [3:0] ACK_FIRST_STATE      = 4'h4;
    localparam logic [3:0] STATE_COUNT_MAX      = 4'hE;

    typedef enum logic [1:0] {
        OUT_NORMAL = 2'b00,
        OUT_HALT   = 2'b01,
        OUT_TRAP   = 2'b10,
        OUT_RERUN  = 2'b11
    } outcome_t;

    typedef struct packed {
        logic transfer_ack_n;
        logic bus_error_n;
        logic halt_n;
    } term_in_t;

    typedef struct packed {
        logic       done;
        outcome_t   outcome;
        logic       trap;
        logic [7:0] trap_vec;
    } term_out_t;
endpackage

// file: rtl/term_sync.sv
// Three-stage input synchroniser with agreement check
`timescale 1ns/1ps
`default_nettype none
module term_sync (
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire bus_term_pkg::term_in_t din,
    output var  bus_term_pkg::term_in_t dout
);
    import bus_term_pkg::*;
    term_in_t s1, s2, s3, next_dout;

    always_comb begin
        next_dout = dout;
        if (s2 == s3) begin
            next_dout = s3;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s1   <= 3'b111;
            s2   <= 3'b111;
            s3   <= 3'b111;
            dout <= 3'b111;
        end else begin
            s1   <= din;
            s2   <= s1;
            s3   <= s2;
            dout <= next_dout;
        end
    end
endmodule
`default_nettype wire

// file: sim/term_partner.sv
// Model of the external termination control logic
`timescale 1ns/1ps
`default_nettype none
module term_partner #(
    parameter int DLY  = 3,
    parameter int HOLD = 8
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Strobe and scenario select
    input  wire logic       as_n,
    input  wire logic [2:0] mode,
    // Termination pins
    output var  logic       ack_n,
    output var  logic       err_n,
    output var  logic       halt_n
);
    logic [5:0] cnt;
    logic [5:0] rel;

    // Pins move on rising edges only
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt    <= 6'h00;
            rel    <= 6'h00;
            ack_n  <= 1'b1;
            err_n  <= 1'b1;
            halt_n <= 1'b1;
        end else if (!as_n) begin
            cnt <= cnt + 6'h01;
            rel <= 6'h00;
            if (cnt == 6'(DLY)) begin
                ack_n  <= !(mode inside {3'h0, 3'h1, 3'h2, 3'h7});
                err_n  <= !(mode inside {3'h2, 3'h3, 3'h4, 3'h5, 3'h6});
                halt_n <= !(mode inside {3'h1, 3'h3, 3'h4, 3'h7});
            end
            if (cnt == 6'(DLY + 2) && mode == 3'h5) halt_n <= 1'b0;
        end else begin
            cnt   <= 6'h00;
            ack_n <= 1'b1;
            if (rel != 6'h3F) rel <= rel + 6'h01;
            if (mode == 3'h4) begin
                halt_n <= 1'b1;
                if (rel == 6'(HOLD)) err_n <= 1'b1;
            end else if (mode == 3'h7) begin
                // Error raised after a halt end and left asserted
                if (!halt_n) err_n <= 1'b0;
                if (rel == 6'(HOLD)) halt_n <= 1'b1;
            end else begin
                err_n <= 1'b1;
                if (rel == 6'(HOLD)) halt_n <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// file: sim/bus_cycle_termination_bench.sv
// Self-checking bench for the bus cycle termination block
`timescale 1ns/1ps
`default_nettype none
module bus_cycle_termination_bench;
    import bus_term_pkg::*;
    logic       CLK = 1'b0;
    logic       SYS_RST = 1'b1;
    logic       CYCLE_START = 1'b0;
    logic       RMW_CYCLE = 1'b0;
    logic [2:0] mode = 3'h0;
    logic       ack_n, err_n, halt_n, as_n, done, trap, halted, rerun, stretch;
    logic [1:0] outcome;
    logic [7:0] vec;
    logic [1:0] obs_out;
    logic [7:0] obs_vec;
    logic       obs_trap, obs_rerun, obs_halt;
    int         miscompares = 0;
    int         checked = 0;

    always #50 CLK = ~CLK;

    term_partner u_term_partner (.clk(CLK), .rst(SYS_RST), .as_n(as_n), .mode(mode),
        .ack_n(ack_n), .err_n(err_n), .halt_n(halt_n));
    bus_cycle_termination u_bus_cycle_termination (.CLK(CLK), .SYS_RST(SYS_RST),
        .CYCLE_START(CYCLE_START), .RMW_CYCLE(RMW_CYCLE), .TRANSFER_ACK_N(ack_n),
        .BUS_ERROR_N(err_n), .HALT_N(halt_n), .ADDR_STROBE_N(as_n), .CYCLE_DONE(done),
        .OUTCOME(outcome), .TRAP_REQ(trap), .TRAP_VECTOR(vec), .HALTED(halted),
        .RERUN_REQ(rerun), .STRETCH(stretch));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic final_report;
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // One cycle, then watch the aftermath
    task automatic run(input logic [2:0] m, input logic rmw);
        int n;
        n = 0;
        @(negedge CLK);
        mode = m;
        CYCLE_START = 1'b1;
        RMW_CYCLE = rmw;
        @(negedge CLK);
        CYCLE_START = 1'b0;
        @(negedge CLK);
        check(as_n, 8'h00);
        while (done !== 1'b1) begin
            @(negedge CLK);
            n++;
            if (n > 200) begin
                miscompares++;
                final_report();
            end
        end
        obs_out = outcome;
        {obs_trap, obs_rerun, obs_halt, obs_vec} = {3'h0, 8'hFF};
        repeat (40) begin
            @(negedge CLK);
            if (trap === 1'b1) {obs_trap, obs_vec} = {1'b1, vec};
            if (rerun === 1'b1) obs_rerun = 1'b1;
            if (halted === 1'b1) obs_halt = 1'b1;
        end
        check({as_n, halted}, 8'h02);
    endtask

    task automatic sc_normal;
        repeat (2) begin
            run(3'h0, 1'b0);
            check(obs_out, OUT_NORMAL);
            check({obs_trap, obs_rerun, obs_halt}, 8'h00);
        end
    endtask

    task automatic sc_halt;
        run(3'h1, 1'b0);
        check(obs_out, OUT_HALT);
        check({obs_trap, obs_rerun, obs_halt}, 8'h01);
    endtask

    task automatic sc_bus_error;
        for (int i = 0; i < 2; i++) begin
            run(i == 0 ? 3'h2 : 3'h6, 1'b0);
            check(obs_out, OUT_TRAP);
            check({obs_trap, obs_rerun}, 8'h02);
            check(obs_vec, TRAP_VEC_BUS_ERROR);
        end
    endtask

    task automatic sc_rerun;
        for (int i = 0; i < 2; i++) begin
            run(i == 0 ? 3'h3 : 3'h5, 1'b0);
            check(obs_out, OUT_RERUN);
            check({obs_trap, obs_rerun, obs_halt}, 8'h03);
            run(3'h0, 1'b0);
            check(obs_out, OUT_NORMAL);
        end
    endtask

    task automatic sc_illegal;
        run(3'h4, 1'b0);
        check(obs_out, OUT_RERUN);
        check({obs_trap, obs_rerun}, 8'h02);
        check(obs_vec, TRAP_VEC_ILLEGAL);
    endtask

    task automatic sc_rmw;
        run(3'h3, 1'b1);
        check(obs_out, OUT_TRAP);
        check({obs_trap, obs_rerun}, 8'h02);
        check(obs_vec, TRAP_VEC_BUS_ERROR);
    endtask

    // Halt end with error left asserted, then a further cycle
    task automatic sc_stuck;
        int n;
        n = 0;
        run(3'h7, 1'b0);
        check(obs_out, OUT_HALT);
        check({obs_trap, obs_rerun, obs_halt}, 8'h01);
        @(negedge CLK);
        CYCLE_START = 1'b1;
        @(negedge CLK);
        CYCLE_START = 1'b0;
        mode = 3'h6;
        check(stretch, 1'b1);
        while (done !== 1'b1) begin
            @(negedge CLK);
            n++;
            if (n > 200) begin
                miscompares++;
                final_report();
            end
        end
        check(outcome, OUT_TRAP);
        obs_trap = 1'b0;
        repeat (40) begin
            @(negedge CLK);
            if (trap === 1'b1) obs_trap = 1'b1;
        end
        check(obs_trap, 1'b1);
        check(vec, TRAP_VEC_BUS_ERROR);
    endtask

    initial begin
        repeat (20) @(negedge CLK);
        SYS_RST = 1'b0;
        sc_normal();
        sc_halt();
        sc_bus_error();
        sc_rerun();
        sc_illegal();
        sc_rmw();
        sc_stuck();
        final_report();
    end
endmodule
`default_nettype wire
